// *** hdl/ump_pkg.sv ***
// Package with constants and types for the multiprocessor UART receiver filter
// Function
// - Receiver takes 16 samples per bit normally, 8 in double speed.
// - First vote sample is 8 normally, 4 in double speed.
// - Middle vote sample is 9 normally, 5 in double speed.
// - Normal speed, eight bits, accepts about 95.36 to 104.58 percent rate.
// - With filter enabled in standard mode, data frames are discarded, never buffered.
// - Address filtering works only in standard mode, not extended mode.
// - Transmitter behaviour ignores the filter enable bit.
// - With 5 to 8 data bits, first stop bit is frame type.
// - With nine data bits, received ninth bit is frame type.
// - Frame type one means address, zero means data.
// - Address frames under filtering are buffered and flagged like any frame.
// - Filtering slave ignores data frames until next address frame.
// - Transmitter and receiver share one character size setting.
// - Each bit decided by two-of-three vote of centre samples.
// - Double speed select cuts baud divisor from 16 to 8.
package ump_pkg;

    // Wishbone register word offsets (byte addresses)
    localparam logic [3:0] UMP_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] UMP_ADDR_STATUS = 4'h4;
    localparam logic [3:0] UMP_ADDR_DATA   = 4'h8;
    localparam logic [3:0] UMP_ADDR_BAUD   = 4'hC;

    // Control register field positions
    localparam int UMP_CTL_FILTER = 0;
    localparam int UMP_CTL_DOUBLE = 1;
    localparam int UMP_CTL_RXEN   = 2;
    localparam int UMP_CTL_EXT    = 3;
    localparam int UMP_CTL_PAR_EN = 4;
    localparam int UMP_CTL_PAR_OD = 5;
    localparam int UMP_CTL_SIZE   = 8;

    // Reset values
    localparam logic [10:0] UMP_CTRL_RST = 11'h300;
    localparam logic [11:0] UMP_BAUD_RST = 12'h000;

    // Samples per bit, vote positions and nine-bit size code
    localparam logic [3:0] UMP_SPB_NORM   = 4'hF;
    localparam logic [3:0] UMP_SPB_DBL    = 4'h7;
    localparam logic [3:0] UMP_FIRST_NORM = 4'h8;
    localparam logic [3:0] UMP_FIRST_DBL  = 4'h4;
    localparam logic [3:0] UMP_MID_NORM   = 4'h9;
    localparam logic [3:0] UMP_MID_DBL    = 4'h5;
    localparam logic [2:0] UMP_SIZE_NINE  = 3'h7;

    // Receiver states
    typedef enum logic [1:0] {
        UMP_IDLE  = 2'b00,
        UMP_START = 2'b01,
        UMP_BITS  = 2'b10,
        UMP_STOP  = 2'b11
    } ump_rx_state_t;

    // One received character with its status
    typedef struct packed {
        logic       frame_err;
        logic       parity_err;
        logic       ninth;
        logic [7:0] data;
    } ump_char_t;

    // Wishbone request bundle
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } ump_wb_req_t;

endpackage

// *** hdl/ump_vote.sv ***
// Two-of-three majority voter over one bit's centre samples
`timescale 1ns/1ps
`default_nettype none
module ump_vote (
    input  wire logic [2:0] samples_i,
    output logic            bit_o
);
    // Majority of three
    assign bit_o = (samples_i[0] & samples_i[1]) | (samples_i[0] & samples_i[2]) |
                   (samples_i[1] & samples_i[2]);
endmodule
`default_nettype wire

// *** hdl/ump_rxbuf.sv ***
// Two-entry receive buffer holding characters with status
`timescale 1ns/1ps
`default_nettype none
module ump_rxbuf
    import ump_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      flush_i,
    input  wire logic      push_i,
    input  wire ump_char_t push_data_i,
    input  wire logic      pop_i,
    output ump_char_t      head_o,
    output logic [1:0]     count_o
);
    import ump_pkg::*;

    typedef struct packed {
        ump_char_t  e0;
        ump_char_t  e1;
        logic [1:0] cnt;
    } ump_buf_state_t;

    ump_buf_state_t s_reg;
    ump_buf_state_t s_next;

    // Shift-out on pop, append on push
    always_comb begin
        s_next = s_reg;
        if (pop_i && s_reg.cnt != 2'h0) begin
            s_next.e0  = s_reg.e1;
            s_next.cnt = s_reg.cnt - 2'h1;
        end
        if (push_i && s_next.cnt != 2'h2) begin
            if (s_next.cnt == 2'h0) begin
                s_next.e0 = push_data_i;
            end else begin
                s_next.e1 = push_data_i;
            end
            s_next.cnt = s_next.cnt + 2'h1;
        end
        if (flush_i) begin
            s_next.cnt = 2'h0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign head_o  = s_reg.e0;
    assign count_o = s_reg.cnt;
endmodule
`default_nettype wire

// *** hdl/ump_uart_rx.sv ***
// UART receiver with oversampling, majority vote and address filter
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ump_uart_rx (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire ump_pkg::ump_wb_req_t wb_req_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 rxd_i,
    output logic [2:0]                char_size_sel_o,
    output logic                      rx_ready_o
);
    import ump_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [10:0]   ctrl;
        logic [11:0]   baud_divisor;
        logic [11:0]   pre_cnt;
        logic [3:0]    samp_cnt;
        logic [3:0]    bit_cnt;
        logic [2:0]    votes;
        logic [8:0]    shift;
        logic          par_acc;
        logic          overrun_pend;
        logic          overrun_flag;
        logic          rxd_prev;
        ump_rx_state_t st;
        logic          ack;
        logic [31:0]   rdat;
        logic          ready;
    } ump_state_t;

    ump_state_t s_reg;
    ump_state_t s_next;

    ////////////////////////////////////////////////////////////////////
    // Derived controls
    logic       dbl;
    logic       filt_on;
    logic [2:0] size_code;
    logic [3:0] nbits;
    logic [3:0] spb_last;
    logic [3:0] first_s;
    logic [3:0] mid_s;
    logic       tick;
    logic       voted;
    logic       wb_go;
    logic       rd_data;
    logic       frame_type;
    logic       keep_frame;
    logic       push;
    ump_char_t  push_char;
    ump_char_t  head;
    logic [1:0] fill;
    logic       flush;

    assign dbl       = s_reg.ctrl[UMP_CTL_DOUBLE];
    assign filt_on   = s_reg.ctrl[UMP_CTL_FILTER] & ~s_reg.ctrl[UMP_CTL_EXT];
    assign size_code = s_reg.ctrl[UMP_CTL_SIZE +: 3];
    // Data bits from the shared size setting
    assign nbits     = (size_code == UMP_SIZE_NINE) ? 4'h9 :
                       {1'b0, size_code} + 4'h5;
    assign spb_last  = dbl ? UMP_SPB_DBL : UMP_SPB_NORM;
    assign first_s   = dbl ? UMP_FIRST_DBL : UMP_FIRST_NORM;
    assign mid_s     = dbl ? UMP_MID_DBL : UMP_MID_NORM;
    assign tick      = (s_reg.pre_cnt == 12'h000);
    assign wb_go     = wb_req_i.cyc & wb_req_i.stb & ~s_reg.ack;
    assign rd_data   = wb_go & ~wb_req_i.we & (wb_req_i.adr == UMP_ADDR_DATA);
    assign flush     = ~s_reg.ctrl[UMP_CTL_RXEN];

    // Majority vote of the three centre samples
    ump_vote u_vote (
        .samples_i ({rxd_i, s_reg.votes[1:0]}),
        .bit_o     (voted)
    );

    // Frame type: ninth bit for nine-bit frames, first stop bit otherwise
    assign frame_type = (nbits == 4'h9) ? s_reg.shift[8] : voted;
    // Data frames dropped while filtering; address frames kept
    assign keep_frame = ~filt_on | frame_type;

    ////////////////////////////////////////////////////////////////////
    // Two-entry receive buffer
    assign push = (s_reg.st == UMP_STOP) && tick && (s_reg.samp_cnt == first_s + 4'h2)
                  && keep_frame && (fill != 2'h2);
    assign push_char.frame_err  = ~voted;
    assign push_char.parity_err = s_reg.ctrl[UMP_CTL_PAR_EN] &
                                  (s_reg.par_acc ^ s_reg.ctrl[UMP_CTL_PAR_OD]);
    assign push_char.ninth      = (nbits == 4'h9) ? s_reg.shift[8] : 1'b0;
    assign push_char.data       = (nbits == 4'h9) ? s_reg.shift[7:0] :
                                  s_reg.shift[8:1] >> (4'h8 - nbits);

    ump_rxbuf u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .flush_i     (flush),
        .push_i      (push),
        .push_data_i (push_char),
        .pop_i       (rd_data),
        .head_o      (head),
        .count_o     (fill)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_next     = s_reg;
        s_next.ack = 1'b0;
        // Line level remembered per sample tick for start edge detection
        s_next.rxd_prev = tick ? rxd_i : s_reg.rxd_prev;
        s_next.ready = s_reg.ctrl[UMP_CTL_RXEN];

        // Sample tick prescaler from baud divisor
        s_next.pre_cnt = tick ? s_reg.baud_divisor : s_reg.pre_cnt - 12'h001;

        if (tick) begin
            unique case (s_reg.st)
                UMP_IDLE: begin
                    // High to low transition only; a low stop bit is no start
                    if (s_reg.rxd_prev && !rxd_i && s_reg.ctrl[UMP_CTL_RXEN]) begin
                        s_next.st       = UMP_START;
                        s_next.samp_cnt = 4'h2;
                    end
                end
                UMP_START: begin
                    s_next.samp_cnt = s_reg.samp_cnt + 4'h1;
                    if (s_reg.samp_cnt == first_s || s_reg.samp_cnt == mid_s) begin
                        s_next.votes = {s_reg.votes[1:0], rxd_i};
                    end
                    if (s_reg.samp_cnt == first_s + 4'h2) begin
                        if (voted) begin
                            s_next.st = UMP_IDLE; // Noise spike
                        end else begin
                            s_next.st      = UMP_BITS;
                            s_next.bit_cnt = 4'h0;
                            s_next.par_acc = 1'b0;
                            // Overrun memorised when buffer full at new start
                            s_next.overrun_pend = (fill == 2'h2);
                        end
                    end
                    if (s_reg.samp_cnt == spb_last) begin
                        s_next.samp_cnt = 4'h0;
                    end
                end
                UMP_BITS, UMP_STOP: begin
                    s_next.samp_cnt = (s_reg.samp_cnt == spb_last) ? 4'h0 :
                                      s_reg.samp_cnt + 4'h1;
                    if (s_reg.samp_cnt == first_s || s_reg.samp_cnt == mid_s) begin
                        s_next.votes = {s_reg.votes[1:0], rxd_i};
                    end
                    if (s_reg.samp_cnt == first_s + 4'h2) begin
                        if (s_reg.st == UMP_STOP) begin
                            s_next.st = UMP_IDLE;
                            if (keep_frame && s_reg.overrun_pend) begin
                                s_next.overrun_flag = 1'b1;
                            end
                        end else begin
                            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                            s_next.par_acc = s_reg.par_acc ^ voted;
                            if (s_reg.bit_cnt < nbits) begin
                                s_next.shift = (nbits == 4'h9) ?
                                    {voted, s_reg.shift[8:1]} : {voted, s_reg.shift[8:1]};
                            end
                            if (s_reg.bit_cnt ==
                                nbits - {3'h0, ~s_reg.ctrl[UMP_CTL_PAR_EN]}) begin
                                s_next.st = UMP_STOP;
                            end
                        end
                    end
                end
            endcase
        end

        // Wishbone slave
        if (wb_go) begin
            s_next.ack  = 1'b1;
            s_next.rdat = 32'h0000_0000;
            if (wb_req_i.we) begin
                if (wb_req_i.adr == UMP_ADDR_CTRL) begin
                    if (wb_req_i.sel[0]) s_next.ctrl[7:0] = wb_req_i.dat[7:0];
                    if (wb_req_i.sel[1]) s_next.ctrl[10:8] = wb_req_i.dat[10:8];
                end else if (wb_req_i.adr == UMP_ADDR_BAUD) begin
                    if (wb_req_i.sel[0]) s_next.baud_divisor[7:0] = wb_req_i.dat[7:0];
                    if (wb_req_i.sel[1]) s_next.baud_divisor[11:8] = wb_req_i.dat[11:8];
                end
            end else begin
                unique case (wb_req_i.adr)
                    UMP_ADDR_CTRL:   s_next.rdat = {21'h0, s_reg.ctrl};
                    UMP_ADDR_STATUS: s_next.rdat = {26'h0, fill, s_reg.overrun_flag,
                                                    head.parity_err & (fill != 2'h0),
                                                    head.frame_err & (fill != 2'h0),
                                                    fill != 2'h0};
                    UMP_ADDR_DATA:   s_next.rdat = {23'h0, head.ninth, head.data};
                    UMP_ADDR_BAUD:   s_next.rdat = {20'h0, s_reg.baud_divisor};
                    default:         s_next.rdat = 32'h0000_0000;
                endcase
                if (rd_data) begin
                    s_next.overrun_flag = 1'b0;
                end
            end
        end

        // Receiver disable aborts reception and flags
        if (flush) begin
            s_next.st           = UMP_IDLE;
            s_next.overrun_flag = 1'b0;
            s_next.overrun_pend = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg      <= '0;
            s_reg.ctrl <= UMP_CTRL_RST;
            s_reg.baud_divisor <= UMP_BAUD_RST;
            s_reg.rxd_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o        = s_reg.rdat;
    assign wb_ack_o        = s_reg.ack;
    assign char_size_sel_o = s_reg.ctrl[UMP_CTL_SIZE +: 3];
    assign rx_ready_o      = s_reg.ready;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // none
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    a_drop_data_frame: assert property (@(posedge clk_i) disable iff (rst_i)
        (filt_on && !frame_type && s_reg.st == UMP_STOP) |-> !push)
        else $error("data frame buffered while filtering");
    a_keep_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_reg.st == UMP_STOP && tick && s_reg.samp_cnt == first_s + 4'h2 &&
         frame_type && fill == 2'h0) |-> push) else $error("address frame lost");
    a_ext_no_filter: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.ctrl[UMP_CTL_EXT] |-> !filt_on) else $error("filter in extended mode");
    a_spb_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        spb_last == (dbl ? 4'h7 : 4'hF)) else $error("wrong samples per bit");
    a_first_vote: assert property (@(posedge clk_i) disable iff (rst_i)
        first_s == (dbl ? 4'h4 : 4'h8)) else $error("wrong first vote sample");
    a_mid_vote: assert property (@(posedge clk_i) disable iff (rst_i)
        mid_s == (dbl ? 4'h5 : 4'h9)) else $error("wrong middle vote sample");
    a_fill_pop: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_data && fill == 2'h1 && !push && !flush) |=> fill == 2'h0)
        else $error("buffer not popped");
endmodule
`default_nettype wire

// *** tb/ump_node.sv ***
// Remote UART node model driving the shared serial line
`timescale 1ns/1ps
`default_nettype none
module ump_node (
    input  wire logic clk_i,
    output logic      txd_o
);
    // Line idles high between frames
    initial txd_o = 1'h1;

    // One bit level held for bclk clocks, optional two-clock spike mid-bit
    task automatic drive_bit(input logic b, input int bclk, input bit spike);
        for (int c = 0; c < bclk; c++) begin
            @(posedge clk_i);
            txd_o <= (spike && c >= bclk / 2 && c < bclk / 2 + 2) ? ~b : b;
        end
    endtask

    // Start, data LSB first, frame type in first stop, second stop, idle
    task automatic send_frame(input logic [8:0] word, input int nb, input logic stop1,
                              input int bclk, input bit spike);
        drive_bit(1'h0, bclk, 1'h0);
        for (int i = 0; i < nb; i++) begin
            drive_bit(word[i], bclk, spike);
        end
        drive_bit(stop1, bclk, 1'h0);
        drive_bit(1'h1, bclk, 1'h0);
        drive_bit(1'h1, bclk, 1'h0);
    endtask
endmodule
`default_nettype wire

// *** tb/test_uart_multiproc_address_filter.sv ***
// Self-checking testbench for the multiprocessor UART receiver filter
`timescale 1ns/1ps
`default_nettype none
module test_uart_multiproc_address_filter;
    import ump_pkg::*;
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    ump_wb_req_t wb_req = '0;
    logic [31:0] wb_dat;
    logic        wb_ack;
    logic        rxd;
    logic [2:0]  size_sel;
    logic        rx_ready;
    logic [31:0] q;
    logic [7:0]  d8;
    int          fails = 0;
    int          total_checks = 0;
    int          nbs [7] = '{9, 9, 9, 8, 8, 5, 9};
    bit          flt [7] = '{1, 0, 1, 1, 0, 1, 1};
    bit          dbl [7] = '{0, 0, 1, 0, 0, 1, 0};
    bit          ext [7] = '{0, 0, 0, 0, 0, 0, 1};
    int          bcl [7] = '{32, 31, 16, 33, 32, 16, 32};
    bit          spk [7] = '{1, 0, 1, 0, 0, 0, 1};

    // Clock at 100 MHz
    always #5 clk_i = ~clk_i;

    ump_uart_rx DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat),
                     .wb_ack_o(wb_ack), .rxd_i(rxd), .char_size_sel_o(size_sel),
                     .rx_ready_o(rx_ready));
    ump_node node (.clk_i(clk_i), .txd_o(rxd));

    ////////////////////////////////////////////////////////////////////////////
    // Comparison and verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Classic Wishbone single cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] d,
                           output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{cyc: 1'h1, stb: 1'h1, we: we, sel: 4'hF, adr: a, dat: d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'h1 && n < 50);
        r = wb_dat;
        wb_req <= '0;
        if (n >= 50) begin
            fails++;
            final_report();
        end
    endtask

    // Frame kept unless filtering drops a data frame
    function automatic bit exp_keep(input bit filt, input bit ex, input logic t);
        return !filt || ex || t;
    endfunction

    // Program mode and check the shared size code
    task automatic setmode(input int nb, input bit filt, input bit db, input bit ex);
        logic [31:0] r;
        logic [2:0]  code;
        code = (nb == 9) ? UMP_SIZE_NINE : 3'(nb - 5);
        wb_xfer(1'h1, UMP_ADDR_CTRL, {21'h0, code, 4'h0, ex, 1'h1, db, filt}, r);
        repeat (2) @(posedge clk_i);
        chk(32'(size_sel), 32'(code));
    endtask

    // Send one frame and check status and buffered character
    task automatic check_frame(input int nb, input bit filt, input bit ex, input int bclk,
                               input bit spike, input int tsel);
        logic [31:0] r;
        logic [7:0]  d;
        logic        t;
        bit          keep;
        d = 8'($urandom) & ((nb >= 8) ? 8'hFF : 8'((1 << nb) - 1));
        t = (tsel < 0) ? 1'($urandom) : 1'(tsel);
        node.send_frame((nb == 9) ? {t, d} : {1'h0, d}, nb, (nb == 9) ? 1'h1 : t,
                        bclk, spike);
        keep = exp_keep(filt, ex, t);
        wb_xfer(1'h0, UMP_ADDR_STATUS, 32'h0, r);
        chk(32'(r[3:0]), 32'({2'h0, keep && nb < 9 && !t, keep}));
        if (keep) begin
            wb_xfer(1'h0, UMP_ADDR_DATA, 32'h0, r);
            chk(32'(r[7:0]), 32'(d));
            if (nb == 9) chk(32'(r[8]), 32'(t));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (90000) @(posedge clk_i);
        fails++;
        final_report();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h5D0F5D81));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk(32'(size_sel), 32'h3);
        chk(32'(rx_ready), 32'h0);
        wb_xfer(1'h0, UMP_ADDR_CTRL, 32'h0, q);
        chk(q, 32'(UMP_CTRL_RST));
        wb_xfer(1'h0, UMP_ADDR_STATUS, 32'h0, q);
        chk(q, 32'h0);
        wb_xfer(1'h0, UMP_ADDR_BAUD, 32'h0, q);
        chk(q, 32'(UMP_BAUD_RST));
        wb_xfer(1'h0, 4'h2, 32'h0, q);
        chk(q, 32'h0);
        // Tick every second clock: 32 clocks a bit normal, 16 doubled
        wb_xfer(1'h1, UMP_ADDR_BAUD, 32'h1, q);
        wb_xfer(1'h0, UMP_ADDR_BAUD, 32'h0, q);
        chk(q, 32'h1);
        for (int m = 0; m < 7; m++) begin
            setmode(nbs[m], flt[m], dbl[m], ext[m]);
            chk(32'(rx_ready), 32'h1);
            repeat (6) check_frame(nbs[m], flt[m], ext[m], bcl[m], spk[m], -1);
        end
        // Slave software: address seen, filter off, data, filter back on
        setmode(9, 1'h1, 1'h0, 1'h0);
        check_frame(9, 1'h1, 1'h0, 32, 1'h0, 1);
        setmode(9, 1'h0, 1'h0, 1'h0);
        check_frame(9, 1'h0, 1'h0, 32, 1'h0, 0);
        setmode(9, 1'h1, 1'h0, 1'h0);
        check_frame(9, 1'h1, 1'h0, 32, 1'h0, 0);
        // Eight bits plus even parity, good then bad parity bit
        wb_xfer(1'h1, UMP_ADDR_CTRL, 32'h0000_0314, q);
        for (int p = 0; p < 2; p++) begin
            d8 = 8'($urandom);
            node.send_frame({(^d8) ^ 1'(p), d8}, 9, 1'h1, 32, 1'h0);
            wb_xfer(1'h0, UMP_ADDR_STATUS, 32'h0, q);
            chk(32'(q[3:0]), 32'({1'h0, 1'(p), 2'h1}));
            wb_xfer(1'h0, UMP_ADDR_DATA, 32'h0, q);
            chk(32'(q[7:0]), 32'(d8));
        end
        final_report();
    end
endmodule
`default_nettype wire
